// ### hw/mdc_dma.sv
// Four-channel DMA controller: registers, arbiter and transfer engine
//
// Notes on behaviour
// RQ1 - Each channel moves data one way only, set by its direction bit.
// RQ2 - Software needing both directions to one peripheral uses two channels.
// RQ3 - Simultaneous requests are granted by fixed priority, channel 0 first.
// RQ4 - A channel raises its interrupt line when its block completes.
// RQ5 - Timer and external interrupt events can trigger channel transfers.
// RQ6 - SRAM address either post-increments each transfer or stays fixed.
// RQ7 - Peripheral-indirect mode takes the SRAM address from the peripheral.
// RQ8 - Interrupt fires at half block or at full block, selectable.
// RQ9 - Each channel moves single bytes or full words.
// RQ10 - Transfers start by software force or by the selected peripheral.
// RQ11 - One-shot stops after one block; auto-repeat restarts the block.
// RQ12 - Ping-pong alternates two SRAM start addresses after each block.
// RQ13 - An 8-bit source code picks the request from any event source.
// RQ14 - Code 00000000 picks external interrupt 0 with no peripheral address.
// RQ15 - Code 00000101 picks input capture 2, read from 0x014C.
// RQ16 - Code 00000110 picks output compare 2, writing 0x0910 or 0x090E.
// RQ17 - Code 00001011 picks UART1 receive, read from 0x0226.
// RQ18 - Code 00001100 picks UART1 transmit, written at 0x0224.
// RQ19 - Code 00001101 picks converter 1 done, read from 0x0300.
// RQ20 - A request losing arbitration stays pending until it is served.
`include "mdc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

// Register map, one window of 0x20 bytes per channel at channel * 0x20:
//   0x00 control   [0] enable, [1] direction (1 = SRAM to peripheral),
//                  [2] byte mode, [4:3] address mode (0 step, 1 fixed,
//                  2 peripheral offset), [5] auto-repeat, [6] ping-pong,
//                  [7] half-block interrupt, [8] trigger by event
//   0x04 request   [7:0] source code, [15] software force (reads 0);
//                  writing it also loads the default peripheral address
//   0x08 start A   SRAM start address of the first buffer
//   0x0C start B   SRAM start address of the second buffer
//   0x10 periph    peripheral data address, write after the request
//   0x14 length    transfers per block, 0 counts as 1
//   0x18 status    [0] done, [1] half (both write one to clear),
//                  [2] buffer in use, [3] request pending
//   0x1C progress  transfers done in the current block
// Addresses with bit 7 set or an unlisted offset read 0, ignore writes.
//
// Each transfer takes four cycles: read issue, read wait, capture with
// write issue, write end. The next grant is made in the idle cycle that follows,
// which is also the read issue, so the lowest pending channel is picked from settled state.
// Writing the request register reloads the peripheral address, so an
// override of that address must follow the request write.

module mdc_dma (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  input  wire logic [255:0]        src_events,
  input  wire logic [3:0][15:0]    pia_addr,
  output mdc_pkg::mdc_mem_s        mem_bus,
  input  wire logic [15:0]         mem_rdata,
  output logic      [3:0]          block_irq
);

  // Default peripheral data address for a source code
  function automatic logic [15:0] pad_default(input logic [7:0] code);
    logic [15:0] a;
    a = `MDC_PAD_NONE;
    if (code == `MDC_SRC_INT0) begin
      a = `MDC_PAD_NONE; // RQ14
    end else if (code == `MDC_SRC_IC2) begin
      a = `MDC_PAD_IC2; // RQ15
    end else if (code == `MDC_SRC_OC2) begin
      a = `MDC_PAD_OC2_MAIN; // RQ16
    end else if (code == `MDC_SRC_U1RX) begin
      a = `MDC_PAD_U1RX; // RQ17
    end else if (code == `MDC_SRC_U1TX) begin
      a = `MDC_PAD_U1TX; // RQ18
    end else if (code == `MDC_SRC_ADC1) begin
      a = `MDC_PAD_ADC1; // RQ19
    end
    return a;
  endfunction

  // Engine state and outputs
  mdc_pkg::mdc_state_e st_q;
  mdc_pkg::mdc_mem_s   mem_q;
  logic [1:0]          gnt_q;
  logic [15:0]         rdata_q;
  logic [3:0]          irq_q;
  logic [15:0]         dst_q;

  // Per-channel views gathered from the generate loop
  logic [3:0][15:0]    ch_rdata;
  logic [3:0][15:0]    ch_src;
  logic [3:0][15:0]    ch_dst;
  logic [3:0]          ch_byte;
  logic [3:0]          ch_pend;
  logic [3:0]          ch_irq_d;

  // Bus decode
  wire        reg_in_map = (reg_addr[7] == 1'b0);
  wire [1:0]  reg_ch     = reg_addr[6:5];
  wire [4:0]  reg_ofs    = reg_addr[4:0];

  // Fixed-priority arbiter, lowest channel number wins
  logic [1:0] arb_idx;
  logic       arb_any;
  always_comb begin
    arb_idx = 2'h0;
    arb_any = 1'b0;
    for (int i = `MDC_NUM_CH - 1; i >= 0; i--) begin
      if (ch_pend[i]) begin
        arb_idx = 2'(i); // RQ3
        arb_any = 1'b1;
      end
    end
  end

  wire grant_now = (st_q == mdc_pkg::ST_IDLE) && arb_any;

  // Per-channel registers, triggers and block bookkeeping
  for (genvar c = 0; c < `MDC_NUM_CH; c++) begin : g_ch
    mdc_pkg::mdc_ctrl_s ctrl_q;
    logic [7:0]  code_q;
    logic [15:0] sta_q, stb_q, pad_q, len_q, cur_q, idx_q;
    logic        buf_q, done_q, half_q, pend_q;

    wire sel    = reg_in_map && (reg_ch == 2'(c));
    wire wr_ctl = reg_wr && sel && (reg_ofs == `MDC_OFS_CTRL);
    wire wr_req = reg_wr && sel && (reg_ofs == `MDC_OFS_REQ);
    wire wr_sta = reg_wr && sel && (reg_ofs == `MDC_OFS_STA);
    wire wr_stb = reg_wr && sel && (reg_ofs == `MDC_OFS_STB);
    wire wr_pad = reg_wr && sel && (reg_ofs == `MDC_OFS_PAD);
    wire wr_len = reg_wr && sel && (reg_ofs == `MDC_OFS_LEN);
    wire wr_st  = reg_wr && sel && (reg_ofs == `MDC_OFS_STAT);
    mdc_pkg::mdc_ctrl_s new_ctrl;
    assign new_ctrl = mdc_pkg::mdc_ctrl_s'(reg_wdata);
    wire start  = wr_ctl && new_ctrl.enable && !ctrl_q.enable;

    // Trigger from the selected event or a software force
    wire ev_hit = src_events[code_q]; // RQ13 RQ5
    wire sw_go  = wr_req && reg_wdata[`MDC_REQ_FORCE_BIT];
    wire trig   = ctrl_q.enable &&
                  ((ctrl_q.auto_trig && ev_hit) || sw_go); // RQ10
    wire served = grant_now && (arb_idx == 2'(c));

    // Completion of one transfer of this channel
    wire        step   = (st_q == mdc_pkg::ST_WR) && (gnt_q == 2'(c));
    wire [15:0] idx_nx = idx_q + 16'h0001;
    wire        last   = (idx_nx >= len_q);
    wire        at_hlf = (idx_nx == {1'b0, len_q[15:1]});
    wire [15:0] base   = buf_q ? stb_q : sta_q;
    wire [15:0] inc    = ctrl_q.byte_mode ? `MDC_STEP_BYTE
                                          : `MDC_STEP_WORD; // RQ9
    wire [15:0] sram   = (ctrl_q.amode == `MDC_AMODE_PIA)
                         ? 16'(base + pia_addr[c]) : cur_q; // RQ7

    // One direction per configuration
    assign ch_src[c]  = ctrl_q.dir ? sram : pad_q; // RQ1
    assign ch_dst[c]  = ctrl_q.dir ? pad_q : sram; // RQ1
    assign ch_byte[c] = ctrl_q.byte_mode;
    assign ch_pend[c] = pend_q;
    assign ch_irq_d[c] = step && ((ctrl_q.half_irq && at_hlf && !last) ||
                                  (!ctrl_q.half_irq && last)); // RQ8 RQ4

    // Register read view, unlisted offsets read zero
    wire [15:0] stat_w = {12'h000, pend_q, buf_q, half_q, done_q};
    logic [15:0] rview;
    always_comb begin
      rview = `MDC_RST_WORD;
      if (reg_ofs == `MDC_OFS_CTRL) begin
        rview = 16'(ctrl_q);
      end else if (reg_ofs == `MDC_OFS_REQ) begin
        rview = {8'h00, code_q}; // Force bit always reads zero
      end else if (reg_ofs == `MDC_OFS_STA) begin
        rview = sta_q;
      end else if (reg_ofs == `MDC_OFS_STB) begin
        rview = stb_q;
      end else if (reg_ofs == `MDC_OFS_PAD) begin
        rview = pad_q;
      end else if (reg_ofs == `MDC_OFS_LEN) begin
        rview = len_q;
      end else if (reg_ofs == `MDC_OFS_STAT) begin
        rview = stat_w;
      end else if (reg_ofs == `MDC_OFS_PROG) begin
        rview = idx_q;
      end
    end
    assign ch_rdata[c] = rview;

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        code_q <= `MDC_RST_CODE;
        sta_q  <= `MDC_RST_WORD;
        stb_q  <= `MDC_RST_WORD;
        pad_q  <= `MDC_RST_WORD;
        len_q  <= `MDC_RST_WORD;
      end else begin
        if (wr_req) code_q <= reg_wdata[7:0]; // RQ13
        if (wr_sta) sta_q <= reg_wdata;
        if (wr_stb) stb_q <= reg_wdata;
        if (wr_req) pad_q <= pad_default(reg_wdata[7:0]);
        else if (wr_pad) pad_q <= reg_wdata; // RQ16
        if (wr_len) len_q <= reg_wdata;
      end
    end

    // Pending request: a new trigger wins over the grant clear
    // Repeated triggers while pending merge into one transfer; a held
    // event level re-arms the channel on every cycle it stays high.
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) pend_q <= 1'b0;
      else pend_q <= trig || (pend_q && !served); // RQ20
    end

    // Control, address walk and block modes
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        ctrl_q <= mdc_pkg::mdc_ctrl_s'(`MDC_RST_WORD);
        cur_q  <= `MDC_RST_WORD;
        idx_q  <= `MDC_RST_WORD;
        buf_q  <= 1'b0;
      end else if (wr_ctl) begin
        ctrl_q <= new_ctrl;
        if (start) begin
          cur_q <= sta_q;
          idx_q <= `MDC_RST_WORD;
          buf_q <= 1'b0;
        end
      end else if (step) begin
        if (last) begin
          idx_q <= `MDC_RST_WORD;
          buf_q <= ctrl_q.pingpong ? !buf_q : buf_q; // RQ12
          cur_q <= (ctrl_q.pingpong && !buf_q) ? stb_q : sta_q; // RQ12
          if (!ctrl_q.rpt) ctrl_q.enable <= 1'b0; // RQ11
        end else begin
          idx_q <= idx_nx;
          if (ctrl_q.amode == `MDC_AMODE_INC)
            cur_q <= 16'(cur_q + inc); // RQ6
        end
      end
    end

    // Sticky status: hardware set wins over write-one clear
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        done_q <= 1'b0;
        half_q <= 1'b0;
      end else begin
        done_q <= (step && last) ||
                  (done_q && !(wr_st && reg_wdata[`MDC_STAT_DONE_BIT]));
        half_q <= (step && at_hlf) ||
                  (half_q && !(wr_st && reg_wdata[`MDC_STAT_HALF_BIT]));
      end
    end
  end

  // Read data for the addressed register
  wire [15:0] rd_sel = reg_in_map ? ch_rdata[reg_ch] : `MDC_RST_WORD;

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rdata_q <= `MDC_RST_WORD;
    else rdata_q <= reg_rd ? rd_sel : `MDC_RST_WORD;
  end

  // Block interrupt pulses
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) irq_q <= 4'h0;
    else irq_q <= ch_irq_d; // RQ4
  end

  // Transfer engine: read source, capture, write destination
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= mdc_pkg::ST_IDLE;
      gnt_q <= 2'h0;
      dst_q <= `MDC_RST_WORD;
      mem_q <= '0;
    end else begin
      case (st_q)
        mdc_pkg::ST_IDLE: begin
          mem_q.wr <= 1'b0;
          if (arb_any) begin
            gnt_q          <= arb_idx; // RQ3
            dst_q          <= ch_dst[arb_idx];
            mem_q.addr     <= ch_src[arb_idx];
            mem_q.byte_sel <= ch_byte[arb_idx];
            mem_q.rd       <= 1'b1;
            st_q           <= mdc_pkg::ST_RD;
          end
        end
        // Memory answers the read in the cycle after it sees the strobe
        mdc_pkg::ST_RD: begin
          mem_q.rd <= 1'b0;
          st_q     <= mdc_pkg::ST_CAP;
        end
        // Byte transfers keep only the low lane of the read data
        mdc_pkg::ST_CAP: begin
          mem_q.addr  <= dst_q;
          mem_q.wdata <= mem_q.byte_sel ? {8'h00, mem_rdata[7:0]}
                                        : mem_rdata; // RQ9
          mem_q.wr    <= 1'b1;
          st_q        <= mdc_pkg::ST_WR;
        end
        // Write ends; channel bookkeeping updates on this same edge
        mdc_pkg::ST_WR: begin
          mem_q.wr <= 1'b0;
          st_q     <= mdc_pkg::ST_IDLE;
        end
        default: st_q <= mdc_pkg::ST_IDLE;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign mem_bus   = mem_q;
  assign block_irq = irq_q;

endmodule

`default_nettype wire

// ### hw/mdc_defines.svh
// Register offsets, field positions, reset values and codes of the DMA block
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH

`define MDC_NUM_CH       4
`define MDC_CH_STRIDE    8'h20
`define MDC_OFS_CTRL     5'h00
`define MDC_OFS_REQ      5'h04
`define MDC_OFS_STA      5'h08
`define MDC_OFS_STB      5'h0C
`define MDC_OFS_PAD      5'h10
`define MDC_OFS_LEN      5'h14
`define MDC_OFS_STAT     5'h18
`define MDC_OFS_PROG     5'h1C

`define MDC_REQ_FORCE_BIT  15
`define MDC_STAT_DONE_BIT  0
`define MDC_STAT_HALF_BIT  1
`define MDC_STAT_BUF_BIT   2
`define MDC_STAT_PEND_BIT  3

`define MDC_RST_WORD     16'h0000
`define MDC_RST_CODE     8'h00

`define MDC_AMODE_INC    2'h0
`define MDC_AMODE_FIXED  2'h1
`define MDC_AMODE_PIA    2'h2

`define MDC_SRC_INT0     8'h00
`define MDC_SRC_IC2      8'h05
`define MDC_SRC_OC2      8'h06
`define MDC_SRC_U1RX     8'h0B
`define MDC_SRC_U1TX     8'h0C
`define MDC_SRC_ADC1     8'h0D
`define MDC_PAD_NONE     16'h0000
`define MDC_PAD_IC2      16'h014C
`define MDC_PAD_OC2_MAIN 16'h0910
`define MDC_PAD_OC2_SEC  16'h090E
`define MDC_PAD_U1RX     16'h0226
`define MDC_PAD_U1TX     16'h0224
`define MDC_PAD_ADC1     16'h0300

`define MDC_STEP_BYTE    16'h0001
`define MDC_STEP_WORD    16'h0002

`endif

// ### hw/mdc_pkg.sv
// Types shared by the DMA controller
package mdc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD,
    ST_CAP,
    ST_WR
  } mdc_state_e;

  typedef struct packed {
    logic [6:0] rsvd;
    logic       auto_trig;
    logic       half_irq;
    logic       pingpong;
    logic       rpt;
    logic [1:0] amode;
    logic       byte_mode;
    logic       dir;
    logic       enable;
  } mdc_ctrl_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        byte_sel;
  } mdc_mem_s;

endpackage

// ### bench/mdc_dma_props.sv
// Checker of transfer timing at the DMA controller ports
`timescale 1ns/1ns
`default_nettype none
module mdc_dma_props (
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire mdc_pkg::mdc_mem_s mem_bus,
  input wire logic [3:0]        block_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // A transfer is a read, a write two cycles on, then a gap
  property p_rd_wr; mem_bus.rd |-> ##2 mem_bus.wr; endproperty
  property p_wr_rd; mem_bus.wr |-> $past(mem_bus.rd, 2); endproperty
  property p_one; mem_bus.rd |=> (!mem_bus.rd)[*3]; endproperty
  property p_both; !(mem_bus.rd && mem_bus.wr); endproperty
  property p_byte;
    mem_bus.wr && mem_bus.byte_sel |-> mem_bus.wdata[15:8] == 8'h00;
  endproperty
  // Interrupt pulses follow the write that ends a count
  property p_irq; |block_irq |-> $past(mem_bus.wr); endproperty
  property p_hot; $onehot0(block_irq); endproperty
  property p_gap; |block_irq |=> block_irq == 4'h0; endproperty
  a_rd_wr: assert property (p_rd_wr)
    else $error("read without write");
  a_wr_rd: assert property (p_wr_rd)
    else $error("write without read");
  a_one: assert property (p_one)
    else $error("reads overlap");
  a_both: assert property (p_both)
    else $error("read and write together");
  a_byte: assert property (p_byte)
    else $error("byte write upper half");
  a_irq: assert property (p_irq)
    else $error("interrupt without write");
  a_hot: assert property (p_hot)
    else $error("two interrupts at once");
  a_gap: assert property (p_gap)
    else $error("interrupt too long");
  c_byte: cover property (mem_bus.wr && mem_bus.byte_sel);
  c_irq3: cover property (block_irq[3]);
  c_b2b: cover property (mem_bus.wr ##[1:3] mem_bus.rd);
endmodule
bind mdc_dma mdc_dma_props u_props (
  .core_clk (core_clk),
  .rst_b    (rst_b),
  .mem_bus  (mem_bus),
  .block_irq(block_irq)
);
`default_nettype wire

// ### bench/mdc_mem_model.sv
// SRAM and peripheral register model behind the transfer engine
`timescale 1ns/1ns
`default_nettype none
module mdc_mem_model #(
  parameter logic [15:0] PAT_MASK = 16'h5A3C
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire mdc_pkg::mdc_mem_s mem_bus,
  output logic [15:0]            mem_rdata
);
  // Data follow a read by one cycle, then the lines keep toggling
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata <= 16'h0000;
    end else if (mem_bus.rd) begin
      mem_rdata <= mem_bus.addr ^ PAT_MASK;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench of the four-channel DMA controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0]  code;
    logic [1:0]  ch;
    logic        dir;
    logic [15:0] sta;
    logic [15:0] pad;
  } mdc_row_s;
  localparam logic [15:0] PAT_MASK = 16'h5A3C;
  logic              core_clk = 1'h0;
  logic              rst_b = 1'h0;
  logic [7:0]        reg_addr = 8'h00;
  logic [15:0]       reg_wdata = 16'h0000;
  logic              reg_wr = 1'h0;
  logic              reg_rd = 1'h0;
  logic [15:0]       reg_rdata;
  logic [255:0]      src_events = 256'h0;
  logic [3:0][15:0]  pia_addr = 64'h0000_0040_0000_0000;
  mdc_pkg::mdc_mem_s mem_bus;
  logic [15:0]       mem_rdata;
  logic [3:0]        block_irq;
  logic [31:0]       wq[$];
  int                irq_n[4];
  int                error_cnt = 0;
  int                n_checks = 0;
  mdc_row_s          rows[7] = '{
    '{8'h00, 2'h0, 1'h0, 16'h1000, 16'h0000},
    '{8'h05, 2'h1, 1'h0, 16'h1100, 16'h014C},
    '{8'h06, 2'h2, 1'h1, 16'h1200, 16'h0910},
    '{8'h0B, 2'h3, 1'h0, 16'h1300, 16'h0226},
    '{8'h0C, 2'h0, 1'h1, 16'h1400, 16'h0224},
    '{8'h0D, 2'h1, 1'h0, 16'h1500, 16'h0300},
    '{8'h07, 2'h2, 1'h0, 16'h1600, 16'h0000}
  };
  always #20 core_clk = ~core_clk;
  mdc_dma dut_u (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .src_events(src_events),
    .pia_addr  (pia_addr),
    .mem_bus   (mem_bus),
    .mem_rdata (mem_rdata),
    .block_irq (block_irq)
  );
  mdc_mem_model #(.PAT_MASK(PAT_MASK)) mem_u (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .mem_bus  (mem_bus),
    .mem_rdata(mem_rdata)
  );
  // Log every memory write and count interrupt pulses
  always @(posedge core_clk) begin
    if (mem_bus.wr === 1'h1) wq.push_back({mem_bus.addr, mem_bus.wdata});
    for (int i = 0; i < 4; i++) if (block_irq[i] === 1'h1) irq_n[i]++;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr    <= 1'h0;
  endtask
  // Read data are taken in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd   <= 1'h0;
    @(negedge core_clk);
    check({16'h0000, reg_rdata}, {16'h0000, e});
  endtask
  // Enable goes low first so that enabling reloads the channel
  task automatic cfg(input logic [1:0] ch, input logic [7:0] code,
                     input logic [15:0] sta, input logic [15:0] len,
                     input logic [15:0] ctl);
    wr_reg({1'h0, ch, 5'h04}, {8'h00, code});
    wr_reg({1'h0, ch, 5'h08}, sta);
    wr_reg({1'h0, ch, 5'h14}, len);
    wr_reg({1'h0, ch, 5'h00}, 16'h0000);
    wr_reg({1'h0, ch, 5'h00}, ctl);
    wq.delete();
    irq_n = '{0, 0, 0, 0};
  endtask
  task automatic fire(input logic [7:0] c, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      src_events <= 256'h1 << c;
      @(posedge core_clk);
      src_events <= 256'h0;
      repeat (10) @(posedge core_clk);
    end
  endtask
  initial begin
    mdc_row_s r;
    logic [31:0] e;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    rd_reg(8'h00, 16'h0000);
    rd_reg(8'h80, 16'h0000);
    // One word per event at the default peripheral address
    foreach (rows[i]) begin
      r = rows[i];
      e = r.dir ? {r.pad, r.sta ^ PAT_MASK} : {r.sta, r.pad ^ PAT_MASK};
      cfg(r.ch, r.code, r.sta, 16'h0001, {7'h00, 1'h1, 6'h00, r.dir, 1'h1});
      fire(r.code, 1);
      check(32'(wq.size()), 32'h1);
      check(wq[0], e);
      check(32'(irq_n[r.ch]), 32'h1);
    end
    // Two channels raised together
    cfg(2'h2, 8'h20, 16'h2200, 16'h0001, 16'h0101);
    cfg(2'h1, 8'h21, 16'h2100, 16'h0001, 16'h0101);
    @(posedge core_clk);
    src_events <= (256'h1 << 8'h20) | (256'h1 << 8'h21);
    @(posedge core_clk);
    src_events <= 256'h0;
    fire(8'hFF, 1);
    check({16'h0, wq[0][31:16]}, 32'h2100);
    check({16'h0, wq[1][31:16]}, 32'h2200);
    // Bytes, increment, half-block interrupt, one-shot
    cfg(2'h0, 8'h0B, 16'h3000, 16'h0004, 16'h0185);
    fire(8'h0B, 4);
    e = {16'h0, 16'h0226 ^ PAT_MASK};
    for (int k = 0; k < 4; k++) check(wq[k], {16'h3000 + 16'(k), 8'h0, e[7:0]});
    check(32'(irq_n[0]), 32'h1);
    rd_reg(8'h18, 16'h0003);
    rd_reg(8'h00, 16'h0184);
    fire(8'h0B, 1);
    check(32'(wq.size()), 32'h4);
    // Fixed address, ping-pong, auto-repeat
    wr_reg(8'h6C, 16'h6000);
    cfg(2'h3, 8'h1C, 16'h5000, 16'h0002, 16'h0169);
    fire(8'h1C, 4);
    for (int k = 0; k < 4; k++) check({16'h0, wq[k][31:16]}, 32'h5000 + 32'h1000 * (k / 2));
    check(32'(irq_n[3]), 32'h2);
    // Peripheral-indirect destination
    cfg(2'h2, 8'h22, 16'h4000, 16'h0001, 16'h0111);
    fire(8'h22, 1);
    check({16'h0, wq[0][31:16]}, 32'h4040);
    // Events ignored without auto trigger; software force runs
    cfg(2'h1, 8'h23, 16'h4400, 16'h0001, 16'h0001);
    fire(8'h23, 1);
    check(32'(wq.size()), 32'h0);
    wr_reg(8'h24, 16'h8023);
    fire(8'hFF, 1);
    check({16'h0, wq[0][31:16]}, 32'h4400);
    // Second compare register reached by overriding the peripheral address
    cfg(2'h2, 8'h06, 16'h7000, 16'h0001, 16'h0103);
    wr_reg(8'h50, 16'h090E);
    fire(8'h06, 1);
    check({16'h0, wq[0][31:16]}, 32'h090E);
    // Reset in the middle of a transfer
    cfg(2'h0, 8'h0B, 16'h3000, 16'h0004, 16'h0101);
    @(posedge core_clk);
    src_events <= 256'h1 << 8'h0B;
    @(posedge core_clk);
    src_events <= 256'h0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h0;
    @(negedge core_clk);
    check({12'h000, block_irq, reg_rdata}, 32'h0);
    check({mem_bus.addr, 14'h0, mem_bus.rd, mem_bus.wr}, 32'h0);
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    rd_reg(8'h00, 16'h0000);
    rd_reg(8'h18, 16'h0000);
    end_of_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
